/* File: aoms_pkg.sv */
// Constants and carrier types for the converter operation-mode sequencer
package aoms_pkg;

  // Clock rates in kHz and the divider counts derived from them
  localparam int CLK_KHZ = 250000;
  localparam int FAST_KHZ = 4000;
  localparam int SLOW_KHZ = 131;
  localparam int DIV_W = 11;
  localparam logic [DIV_W-1:0] DIV_FAST = DIV_W'(CLK_KHZ / FAST_KHZ);
  localparam logic [DIV_W-1:0] DIV_SLOW = DIV_W'(CLK_KHZ / SLOW_KHZ);

  // Converter clock periods per conversion
  localparam logic [1:0] TICKS_NOCHOP = 2'h2;
  localparam logic [1:0] TICKS_CHOP = 2'h3;

  // Operation mode codes
  typedef enum logic [2:0] {
    MODE_PWRDN = 3'h0,
    MODE_CONT = 3'h1,
    MODE_SINGLE = 3'h2,
    MODE_IDLE = 3'h3,
    MODE_OFFSET = 3'h4,
    MODE_RSVD = 3'h5,
    MODE_ZERO = 3'h6,
    MODE_FULL = 3'h7
  } aoms_mode_e;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_RES0 = 8'h08;
  localparam logic [7:0] OFS_OFF0 = 8'h10;
  localparam logic [7:0] OFS_GAIN0 = 8'h18;
  localparam logic [7:0] OFS_STRIDE = 8'h04;

  // Field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_CLKSEL_BIT = 7;
  localparam int CFG_PEN_BIT = 8;
  localparam int CFG_AEN_BIT = 9;
  localparam int CFG_CHOP_BIT = 10;
  localparam int STAT_RDY0_BIT = 0;
  localparam int STAT_CALDONE_BIT = 2;

  // Reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] OFF_RST = 32'h0000_0000;
  localparam logic [31:0] GAIN_RST = 32'h0080_0000;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } aoms_avm_req_s;

  typedef struct packed {
    logic pri_pwr;
    logic aux_pwr;
    logic amp_pwr;
    logic mod_rst;
    logic zero_sel;
    logic conv_tick;
  } aoms_afe_ctl_s;

endpackage

/* File: aoms_sequencer.sv */
// Operation-mode sequencer with Avalon-MM register slave for a dual converter pair
//
// Behaviour
// - Mode 000 powers down both converters and the input amplifier.
// - Mode 001 converts repeatedly on every enabled converter until mode changes.
// - Continuous results update result registers only while ready flag is clear.
// - Mode 010 makes each enabled converter perform exactly one conversion.
// - After a single conversion the mode falls back to idle by itself.
// - A conversion lasts two converter clocks, or three with chop enabled.
// - Mode 011 keeps converters powered but holds their modulators in reset.
// - Every calibration ends with an automatic return to idle.
// - Mode 100 calibrates offset against an internal zero-volt input.
// - Calibration runs with the currently programmed settings, chop included.
// - Self-offset calibration settles in the same two or three clocks.
// - Offset calibration result goes into that converter's offset coefficient.
// - Offset calibration end sets calibration-done and ready flags.
// - Mode 110 calibrates zero-scale against the voltage at the pins.
// - Mode 111 calibrates full-scale against the voltage at the pins.
// - Full-scale calibration updates the gain coefficient of each enabled converter.
// - Converter clock is 4 MHz with clock select set, 131 kHz clear.
// - Clearing primary enable powers it down and clears its ready flag.
`timescale 1ns/1ps

module aoms_sequencer #(
  parameter int DW = 24
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire aoms_pkg::aoms_avm_req_s avm_req_i,
  output logic [31:0] avm_readdata_o,
  output logic avm_waitrequest_o,
  // Filtered samples from the modulators
  input wire logic [DW-1:0] pri_sample_i,
  input wire logic [DW-1:0] aux_sample_i,
  // Front-end control
  output aoms_pkg::aoms_afe_ctl_s afe_ctl_o
);

  typedef enum logic [2:0] {
    ST_DOWN = 3'b001,
    ST_HOLD = 3'b010,
    ST_CONV = 3'b100
  } aoms_state_e;

  localparam logic [31-DW:0] PAD = '0;

  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_cal(input logic [2:0] m);
    return m == aoms_pkg::MODE_OFFSET || m == aoms_pkg::MODE_ZERO ||
           m == aoms_pkg::MODE_FULL;
  endfunction

  function automatic aoms_state_e state_of(input logic [2:0] m);
    aoms_state_e s;
    unique case (m)
      aoms_pkg::MODE_PWRDN: s = ST_DOWN;
      aoms_pkg::MODE_IDLE, aoms_pkg::MODE_RSVD: s = ST_HOLD;
      default: s = ST_CONV;
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, read data captured in the first cycle
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;

  assign req = avm_req_i.read | avm_req_i.write;
  assign addr = avm_req_i.address;
  assign wdata = avm_req_i.writedata;
  assign be = avm_req_i.byteenable;
  assign wr = avm_req_i.write & ack_reg;
  assign avm_waitrequest_o = req & ~ack_reg;
  assign avm_readdata_o = rdata_reg;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration
  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  logic clksel_reg;
  logic chop_reg;
  logic [1:0] en_reg;
  logic [31:0] cfg_word;
  logic [31:0] cfg_new;
  logic cfg_wr;
  logic done;

  assign cfg_word = {21'h0, chop_reg, en_reg, clksel_reg, 4'h0, mode_reg};
  assign cfg_wr = wr && addr == aoms_pkg::OFS_CFG;
  assign cfg_new = be_merge(cfg_word, wdata, be);

  // A software write in the same cycle as an automatic fall to idle wins
  always_comb begin
    if (cfg_wr) begin
      mode_next = cfg_new[aoms_pkg::CFG_MODE_LSB +: 3];
    end else if (done && mode_reg != aoms_pkg::MODE_CONT) begin
      mode_next = aoms_pkg::MODE_IDLE;
    end else begin
      mode_next = mode_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_reg <= aoms_pkg::CFG_RST[aoms_pkg::CFG_MODE_LSB +: 3];
      clksel_reg <= aoms_pkg::CFG_RST[aoms_pkg::CFG_CLKSEL_BIT];
      en_reg <= aoms_pkg::CFG_RST[aoms_pkg::CFG_PEN_BIT +: 2];
      chop_reg <= aoms_pkg::CFG_RST[aoms_pkg::CFG_CHOP_BIT];
    end else begin
      mode_reg <= mode_next;
      if (cfg_wr) begin
        clksel_reg <= cfg_new[aoms_pkg::CFG_CLKSEL_BIT];
        en_reg <= cfg_new[aoms_pkg::CFG_PEN_BIT +: 2];
        chop_reg <= cfg_new[aoms_pkg::CFG_CHOP_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock divider
  logic [aoms_pkg::DIV_W-1:0] div_cnt_reg;
  logic [aoms_pkg::DIV_W-1:0] div_lim;
  logic tick_reg;

  assign div_lim = (clksel_reg ? aoms_pkg::DIV_FAST : aoms_pkg::DIV_SLOW) - 1'b1;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      div_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= div_cnt_reg >= div_lim;
      div_cnt_reg <= (div_cnt_reg >= div_lim) ? '0 : div_cnt_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  aoms_state_e state_reg;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_last;

  // Calibration keeps the programmed chop choice, so it settles like a conversion
  assign cnt_last = (chop_reg ? aoms_pkg::TICKS_CHOP : aoms_pkg::TICKS_NOCHOP) - 1'b1;
  assign done = state_reg == ST_CONV && tick_reg && cnt_reg == cnt_last;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= ST_DOWN;
    end else begin
      state_reg <= state_of(mode_next);
    end
  end

  // A fresh mode write restarts the conversion from its first clock
  always_ff @(posedge mclk_i) begin
    if (rst_i || state_reg != ST_CONV || cfg_wr) begin
      cnt_reg <= '0;
    end else if (tick_reg) begin
      cnt_reg <= done ? 2'h0 : cnt_reg + 1'b1;
    end
  end

  assign afe_ctl_o.pri_pwr = state_reg != ST_DOWN && en_reg[0];
  assign afe_ctl_o.aux_pwr = state_reg != ST_DOWN && en_reg[1];
  assign afe_ctl_o.amp_pwr = state_reg != ST_DOWN && en_reg[0];
  assign afe_ctl_o.mod_rst = state_reg != ST_CONV;
  assign afe_ctl_o.zero_sel = state_reg == ST_CONV && mode_reg == aoms_pkg::MODE_OFFSET;
  assign afe_ctl_o.conv_tick = state_reg == ST_CONV && tick_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Per-converter results, ready flags and coefficients
  logic [DW-1:0] smp [2];
  logic [DW-1:0] res_reg [2];
  logic [DW-1:0] off_reg [2];
  logic [DW-1:0] gain_reg [2];
  logic [1:0] rdy_reg;
  logic cal_done_reg;
  logic stat_wr;

  assign smp[0] = pri_sample_i;
  assign smp[1] = aux_sample_i;
  assign stat_wr = wr && addr == aoms_pkg::OFS_STAT && be[0];

  for (genvar i = 0; i < 2; i++) begin : g_conv
    localparam logic [7:0] STEP = (i == 0) ? 8'h00 : aoms_pkg::OFS_STRIDE;
    logic hit;
    logic [31:0] off_m;
    logic [31:0] gain_m;
    assign hit = done && en_reg[i];
    assign off_m = be_merge({PAD, off_reg[i]}, wdata, be);
    assign gain_m = be_merge({PAD, gain_reg[i]}, wdata, be);
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        res_reg[i] <= '0;
      end else if (hit && (mode_reg == aoms_pkg::MODE_SINGLE ||
                           (mode_reg == aoms_pkg::MODE_CONT && !rdy_reg[i]))) begin
        res_reg[i] <= smp[i];
      end
    end

    // Setting beats a software clear; losing enable clears outright
    always_ff @(posedge mclk_i) begin
      if (rst_i || !en_reg[i]) begin
        rdy_reg[i] <= 1'b0;
      end else if (hit) begin
        rdy_reg[i] <= 1'b1;
      end else if (stat_wr && wdata[aoms_pkg::STAT_RDY0_BIT + i]) begin
        rdy_reg[i] <= 1'b0;
      end
    end

    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        off_reg[i] <= aoms_pkg::OFF_RST[DW-1:0];
      end else if (hit && (mode_reg == aoms_pkg::MODE_OFFSET ||
                           mode_reg == aoms_pkg::MODE_ZERO)) begin
        off_reg[i] <= smp[i];
      end else if (wr && addr == aoms_pkg::OFS_OFF0 + STEP) begin
        off_reg[i] <= off_m[DW-1:0];
      end
    end

    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        gain_reg[i] <= aoms_pkg::GAIN_RST[DW-1:0];
      end else if (hit && mode_reg == aoms_pkg::MODE_FULL) begin
        gain_reg[i] <= smp[i];
      end else if (wr && addr == aoms_pkg::OFS_GAIN0 + STEP) begin
        gain_reg[i] <= gain_m[DW-1:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cal_done_reg <= 1'b0;
    end else if (done && is_cal(mode_reg)) begin
      cal_done_reg <= 1'b1;
    end else if (stat_wr && wdata[aoms_pkg::STAT_CALDONE_BIT]) begin
      cal_done_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else if (req && !ack_reg) begin
      unique case (addr)
        aoms_pkg::OFS_CFG: rdata_reg <= cfg_word;
        aoms_pkg::OFS_STAT: rdata_reg <= {29'h0, cal_done_reg, rdy_reg};
        aoms_pkg::OFS_RES0: rdata_reg <= {PAD, res_reg[0]};
        aoms_pkg::OFS_RES0 + aoms_pkg::OFS_STRIDE: rdata_reg <= {PAD, res_reg[1]};
        aoms_pkg::OFS_OFF0: rdata_reg <= {PAD, off_reg[0]};
        aoms_pkg::OFS_OFF0 + aoms_pkg::OFS_STRIDE: rdata_reg <= {PAD, off_reg[1]};
        aoms_pkg::OFS_GAIN0: rdata_reg <= {PAD, gain_reg[0]};
        aoms_pkg::OFS_GAIN0 + aoms_pkg::OFS_STRIDE: rdata_reg <= {PAD, gain_reg[1]};
        default: rdata_reg <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  chk_pwrdn_all: assert property (
    state_reg == ST_DOWN |-> !afe_ctl_o.pri_pwr && !afe_ctl_o.aux_pwr && !afe_ctl_o.amp_pwr)
    else $error("power-down left a circuit powered");
  chk_cont_rerun: assert property (
    done && mode_reg == aoms_pkg::MODE_CONT && !cfg_wr |=> state_reg == ST_CONV && cnt_reg == 2'h0)
    else $error("continuous mode stopped after a result");
  chk_ready_gate: assert property (
    mode_reg == aoms_pkg::MODE_CONT && rdy_reg[0] |=> $stable(res_reg[0]))
    else $error("result overwritten while ready was set");
  chk_single_idle: assert property (
    done && mode_reg == aoms_pkg::MODE_SINGLE && !cfg_wr
    |=> mode_reg == aoms_pkg::MODE_IDLE && state_reg == ST_HOLD)
    else $error("single shot did not fall back to idle");
  chk_conv_len: assert property (
    done |-> cnt_reg == (chop_reg ? 2'h2 : 2'h1) && tick_reg)
    else $error("conversion length wrong");
  chk_hold_reset: assert property (
    state_reg == ST_HOLD |-> afe_ctl_o.mod_rst && afe_ctl_o.pri_pwr == en_reg[0])
    else $error("idle did not hold powered converter in reset");
  chk_cal_idle: assert property (
    done && is_cal(mode_reg) && !cfg_wr |=> mode_reg == aoms_pkg::MODE_IDLE)
    else $error("calibration did not return to idle");
  chk_zero_src: assert property (
    state_reg == ST_CONV && mode_reg == aoms_pkg::MODE_OFFSET |-> afe_ctl_o.zero_sel)
    else $error("self-offset not using internal zero");
  chk_offset_store: assert property (
    done && en_reg[0] && mode_reg == aoms_pkg::MODE_OFFSET |=> off_reg[0] == $past(pri_sample_i))
    else $error("offset coefficient not updated");
  chk_cal_flags: assert property (
    done && en_reg[0] && mode_reg == aoms_pkg::MODE_OFFSET && !cfg_wr
    |=> cal_done_reg && rdy_reg[0])
    else $error("calibration flags not set");
  chk_gain_store: assert property (
    done && en_reg[1] && mode_reg == aoms_pkg::MODE_FULL |=> gain_reg[1] == $past(aux_sample_i))
    else $error("gain coefficient not updated");
  chk_enable_clear: assert property (
    !en_reg[0] |=> !rdy_reg[0] || en_reg[0])
    else $error("ready kept after primary disable");
endmodule

/* File: aoms_afe_model.sv */
// Behavioural model of the analog front end and modulators of both converters
`timescale 1ns/1ps

module aoms_afe_model #(
  parameter logic [23:0] NORM_VAL = 24'h123456,
  parameter logic [23:0] ALT_VAL = 24'h2468AC,
  parameter logic [23:0] SHORT_VAL = 24'h000021,
  parameter logic [23:0] FULL_VAL = 24'h7FFF10,
  parameter logic [23:0] ZERO_VAL = 24'h000013
) (
  // Clock
  input wire logic mclk_i,
  // Control from the sequencer and the pin source chosen by the bench
  input wire aoms_pkg::aoms_afe_ctl_s afe_ctl_i,
  input wire logic [1:0] src_sel_i,
  // Filtered samples
  output logic [23:0] pri_sample_o,
  output logic [23:0] aux_sample_o
);

  logic [23:0] junk_reg = 24'h000000;
  logic [23:0] level;

  ////////////////////////////////////////////////////////////////////////////////
  // An idle or unpowered modulator gives garbage that changes every cycle
  always_ff @(posedge mclk_i) begin
    junk_reg <= junk_reg + 24'h5A5A5B;
  end

  always_comb begin
    // Internal 0 V replaces the pins, whichever input pair was selected
    if (afe_ctl_i.zero_sel) begin
      level = ZERO_VAL;
    end else begin
      // Source 2 stands for inputs shorted outside the device
      case (src_sel_i)
        2'h0: level = NORM_VAL;
        2'h1: level = ALT_VAL;
        2'h2: level = SHORT_VAL;
        default: level = FULL_VAL;
      endcase
    end
  end

  assign pri_sample_o = (afe_ctl_i.pri_pwr && !afe_ctl_i.mod_rst) ? level : junk_reg;
  assign aux_sample_o = (afe_ctl_i.aux_pwr && !afe_ctl_i.mod_rst) ? ~level : ~junk_reg;

endmodule

/* File: adc_operation_mode_sequencer_tb_top.sv */
// Self-checking testbench of the converter operation-mode sequencer
`timescale 1ns/1ps

module adc_operation_mode_sequencer_tb_top;

  localparam logic [23:0] NORM = 24'h123456;
  localparam logic [23:0] ALT = 24'h2468AC;
  localparam logic [23:0] SHRT = 24'h000021;
  localparam logic [23:0] FULL = 24'h7FFF10;
  localparam logic [23:0] ZERO = 24'h000013;
  localparam logic [7:0] CFG = aoms_pkg::OFS_CFG;
  localparam logic [7:0] STAT = aoms_pkg::OFS_STAT;

  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  aoms_pkg::aoms_avm_req_s avm_req = '0;
  logic [31:0] avm_readdata;
  logic avm_waitrequest;
  logic [23:0] pri_sample;
  logic [23:0] aux_sample;
  aoms_pkg::aoms_afe_ctl_s afe_ctl;
  logic [1:0] src_sel = 2'h0;
  logic [31:0] rd = 32'h0;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int last_tick = 0;
  int tick_period = 0;
  int tick_cnt = 0;

  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  aoms_sequencer i_aoms_sequencer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .avm_req_i(avm_req),
    .avm_readdata_o(avm_readdata),
    .avm_waitrequest_o(avm_waitrequest),
    .pri_sample_i(pri_sample),
    .aux_sample_i(aux_sample),
    .afe_ctl_o(afe_ctl)
  );

  aoms_afe_model #(.NORM_VAL(NORM), .ALT_VAL(ALT), .SHORT_VAL(SHRT), .FULL_VAL(FULL),
    .ZERO_VAL(ZERO)) i_aoms_afe_model (
    .mclk_i(mclk_i),
    .afe_ctl_i(afe_ctl),
    .src_sel_i(src_sel),
    .pri_sample_o(pri_sample),
    .aux_sample_o(aux_sample)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Converter clock monitor: tick count and spacing of the last two ticks
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (afe_ctl.conv_tick === 1'b1) begin
      tick_cnt <= tick_cnt + 1;
      tick_period <= cyc - last_tick;
      last_tick <= cyc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon transfer; the request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge mclk_i);
    avm_req <= '{read: !wr, write: wr, address: addr, writedata: wdata, byteenable: 4'hF};
    do begin
      @(posedge mclk_i);
      n++;
      if (n > 20) begin
        failures++;
        summarize();
      end
    end while (avm_waitrequest !== 1'b0);
    rd = avm_readdata;
    avm_req <= '0;
  endtask

  task automatic rdc(input string what, input logic [7:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0);
    check(what, rd, exp);
  endtask

  // Poll a register until the masked bits match, bounded
  task automatic poll(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] val);
    int n;
    n = 0;
    rd = ~val;
    while ((rd & mask) !== val) begin
      bus(1'b0, addr, 32'h0);
      n++;
      if (n > 4000) begin
        failures++;
        summarize();
      end
    end
  endtask

  function automatic logic [31:0] cfgw(input logic [2:0] m, input logic fast, input logic chop,
    input logic en0);
    return {21'h0, chop, 1'b1, en0, fast, 4'h0, m};
  endfunction

  // Start a self-ending mode and check length, converter clock and the return to idle
  task automatic run(input logic [2:0] m, input logic fast, input logic chop,
    input logic [1:0] src);
    int t0;
    src_sel <= src;
    bus(1'b1, STAT, 32'h7);
    t0 = tick_cnt;
    bus(1'b1, CFG, cfgw(m, fast, chop, 1'b1));
    poll(CFG, 32'h7, 32'h3);
    check("mode field", rd, cfgw(3'h3, fast, chop, 1'b1));
    check("tick count", 32'(tick_cnt - t0), chop ? 32'h3 : 32'h2);
    check("tick period", 32'(tick_period),
      {21'h0, fast ? aoms_pkg::DIV_FAST : aoms_pkg::DIV_SLOW});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    check("afe power", {29'h0, afe_ctl.pri_pwr, afe_ctl.aux_pwr, afe_ctl.amp_pwr}, 32'h0);
    rdc("cfg", CFG, aoms_pkg::CFG_RST);
    rdc("gain0", aoms_pkg::OFS_GAIN0, aoms_pkg::GAIN_RST);
    rdc("off0", aoms_pkg::OFS_OFF0, aoms_pkg::OFF_RST);
    rdc("unmapped", 8'h40, 32'h0);
    $display("test reset done");

    run(3'h2, 1'b1, 1'b0, 2'h0);
    rdc("res0", aoms_pkg::OFS_RES0, {8'h0, NORM});
    rdc("res1", aoms_pkg::OFS_RES0 + 8'h04, {8'h0, ~NORM});
    rdc("status", STAT, 32'h3);
    check("idle ctl", {30'h0, afe_ctl.pri_pwr, afe_ctl.mod_rst}, 32'h3);
    $display("test single done");

    run(3'h4, 1'b1, 1'b1, 2'h1);
    rdc("off0", aoms_pkg::OFS_OFF0, {8'h0, ZERO});
    rdc("off1", aoms_pkg::OFS_OFF0 + 8'h04, {8'h0, ~ZERO});
    rdc("status", STAT, 32'h7);
    $display("test self offset done");

    run(3'h6, 1'b0, 1'b0, 2'h2);
    rdc("off0", aoms_pkg::OFS_OFF0, {8'h0, SHRT});
    rdc("status", STAT, 32'h7);
    $display("test zero scale done");

    run(3'h7, 1'b1, 1'b1, 2'h3);
    rdc("gain0", aoms_pkg::OFS_GAIN0, {8'h0, FULL});
    rdc("gain1", aoms_pkg::OFS_GAIN0 + 8'h04, {8'h0, ~FULL});
    rdc("off0 kept", aoms_pkg::OFS_OFF0, {8'h0, SHRT});
    $display("test full scale done");

    // Continuous: a set ready flag must hold back every later result
    src_sel <= 2'h0;
    bus(1'b1, STAT, 32'h7);
    bus(1'b1, CFG, cfgw(3'h1, 1'b1, 1'b0, 1'b1));
    poll(STAT, 32'h1, 32'h1);
    src_sel <= 2'h1;
    rdc("res0 first", aoms_pkg::OFS_RES0, {8'h0, NORM});
    while (tick_cnt < 30) begin
      @(posedge mclk_i);
    end
    rdc("res0 held", aoms_pkg::OFS_RES0, {8'h0, NORM});
    rdc("cfg cont", CFG, cfgw(3'h1, 1'b1, 1'b0, 1'b1));
    // A clear that meets a result edge loses to the set, so clear twice
    bus(1'b1, STAT, 32'h1);
    bus(1'b1, STAT, 32'h1);
    poll(STAT, 32'h1, 32'h1);
    rdc("res0 new", aoms_pkg::OFS_RES0, {8'h0, ALT});
    $display("test continuous done");

    bus(1'b1, CFG, cfgw(3'h3, 1'b1, 1'b0, 1'b0));
    repeat (2) @(posedge mclk_i);
    rdc("status", STAT, 32'h2);
    check("pwr", {30'h0, afe_ctl.pri_pwr, afe_ctl.aux_pwr}, 32'h1);
    // Reserved code behaves like idle: powered, modulators held
    bus(1'b1, CFG, cfgw(3'h5, 1'b1, 1'b0, 1'b1));
    repeat (2) @(posedge mclk_i);
    check("reserved ctl", {30'h0, afe_ctl.pri_pwr, afe_ctl.mod_rst}, 32'h3);
    bus(1'b1, CFG, cfgw(3'h0, 1'b1, 1'b0, 1'b1));
    repeat (2) @(posedge mclk_i);
    check("pwrdn", {29'h0, afe_ctl.pri_pwr, afe_ctl.aux_pwr, afe_ctl.amp_pwr}, 32'h0);
    $display("test power done");
    summarize();
  end

endmodule
